//--- verilog/lwm_regs.svh
`ifndef LWM_REGS_SVH
`define LWM_REGS_SVH
`define LWM_NOLOAD_TRIP 1'b0
`define LWM_NOLOAD_WARN 1'b1
`define LWM_CUR_W 16
`define LWM_VAL_W 32
`define LWM_NWARN 8
`define LWM_VAL_MAX 32'sd999999999
`define LWM_VAL_MIN (-32'sd999999999)
`define LWM_BLINK_NS 250000000
`define LWM_CLK_NS 10
`define LWM_BLINK_CYC (`LWM_BLINK_NS / `LWM_CLK_NS)
`define LWM_W_ILO 0
`define LWM_W_IHI 1
`define LWM_W_FLO 2
`define LWM_W_FHI 3
`define LWM_W_RLO 4
`define LWM_W_RHI 5
`define LWM_W_BLO 6
`define LWM_W_BHI 7
`endif

//--- verilog/lwm_pkg.sv
package lwm_pkg;
  typedef enum logic [1:0] {
    LWM_STOPPED = 2'b00,
    LWM_RAMPING = 2'b01,
    LWM_ACTIVE = 2'b10
  } lwm_state_t;
endpackage

//--- verilog/lwm_monitor.sv
`timescale 1ns/1ps
`include "lwm_regs.svh"
module lwm_monitor import lwm_pkg::*; #(
  parameter int unsigned BLINK_CYC = `LWM_BLINK_CYC
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // Drive state
  input wire logic i_running,
  input wire logic i_stop_cmd,
  input wire logic i_at_reference,
  input wire logic i_remote_ref_sel,
  input wire logic i_noload_action,
  // Measurements
  input wire logic [`LWM_CUR_W-1:0] i_motor_current,
  input wire logic [`LWM_CUR_W-1:0] i_output_freq,
  input wire logic signed [`LWM_VAL_W-1:0] i_remote_ref,
  input wire logic signed [`LWM_VAL_W-1:0] i_result_ref,
  input wire logic signed [`LWM_VAL_W-1:0] i_feedback,
  // Limits
  input wire logic [`LWM_CUR_W-1:0] i_max_current,
  input wire logic [`LWM_CUR_W-1:0] low_current_limit,
  input wire logic [`LWM_CUR_W-1:0] high_current_limit,
  input wire logic [`LWM_CUR_W-1:0] i_low_freq_limit,
  input wire logic [`LWM_CUR_W-1:0] high_frequency_limit,
  input wire logic signed [`LWM_VAL_W-1:0] low_reference_limit,
  input wire logic signed [`LWM_VAL_W-1:0] high_reference_limit,
  input wire logic signed [`LWM_VAL_W-1:0] low_feedback_limit,
  input wire logic signed [`LWM_VAL_W-1:0] high_feedback_limit,
  // Routing masks
  input wire logic [`LWM_NWARN-1:0] i_route_sig,
  input wire logic [`LWM_NWARN-1:0] i_route_relay,
  // Results
  output logic [`LWM_NWARN-1:0] o_warn,
  output logic [`LWM_NWARN-1:0] o_warn_flash,
  output logic o_sig_out,
  output logic o_relay_out,
  output logic o_trip,
  output logic o_monitor_en,
  output logic o_limit_err
);

  lwm_state_t state_r;
  lwm_state_t state_nxt;
  logic [`LWM_NWARN-1:0] raw;
  logic [`LWM_NWARN-1:0] warn_nxt;
  logic [`LWM_NWARN-1:0] warn_r;
  logic [`LWM_NWARN-1:0] warn_flash_r;
  logic trip_r;
  logic blink_r;
  logic [31:0] blink_cnt_r;
  logic enable;
  logic [15:0] cur_lo;
  logic [15:0] cur_hi;
  logic signed [31:0] ref_lo;
  logic signed [31:0] ref_hi;
  logic signed [31:0] fb_lo;
  logic signed [31:0] fb_hi;
  logic lim_bad;

  always_comb begin
    cur_hi = high_current_limit;
    if (cur_hi > i_max_current) begin
      cur_hi = i_max_current;
    end
    cur_lo = low_current_limit;
    if (cur_lo > cur_hi) begin
      cur_lo = cur_hi;
    end
  end

  always_comb begin
    ref_hi = high_reference_limit;
    ref_lo = low_reference_limit;
    fb_hi = high_feedback_limit;
    fb_lo = low_feedback_limit;
    if (ref_hi > `LWM_VAL_MAX) ref_hi = `LWM_VAL_MAX;
    if (fb_hi > `LWM_VAL_MAX) fb_hi = `LWM_VAL_MAX;
    if (ref_lo < `LWM_VAL_MIN) ref_lo = `LWM_VAL_MIN;
    if (fb_lo < `LWM_VAL_MIN) fb_lo = `LWM_VAL_MIN;
    if (ref_lo > ref_hi) ref_lo = ref_hi;
    if (fb_lo > fb_hi) fb_lo = fb_hi;
  end

  assign lim_bad = (high_current_limit > i_max_current) ||
                   (low_current_limit > high_current_limit) ||
                   (low_reference_limit > high_reference_limit) ||
                   (low_feedback_limit > high_feedback_limit) ||
                   (high_reference_limit > `LWM_VAL_MAX) ||
                   (low_reference_limit < `LWM_VAL_MIN) ||
                   (high_feedback_limit > `LWM_VAL_MAX) ||
                   (low_feedback_limit < `LWM_VAL_MIN);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      LWM_STOPPED: begin
        if (i_running && !i_stop_cmd) state_nxt = LWM_RAMPING;
      end
      LWM_RAMPING: begin
        if (!i_running) state_nxt = LWM_STOPPED;
        else if (!i_stop_cmd && i_at_reference) state_nxt = LWM_ACTIVE;
      end
      LWM_ACTIVE: begin
        if (!i_running) state_nxt = LWM_STOPPED;
        else if (i_stop_cmd) state_nxt = LWM_RAMPING;
      end
      default: state_nxt = LWM_STOPPED;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) state_r <= LWM_STOPPED;
    else state_r <= state_nxt;
  end

  // Gate also on live inputs so a stop suppresses at once
  assign enable = (state_r == LWM_ACTIVE) && i_running && !i_stop_cmd;

  always_comb begin
    raw = '0;
    raw[`LWM_W_ILO] = i_motor_current < cur_lo;
    raw[`LWM_W_IHI] = i_motor_current > cur_hi;
    raw[`LWM_W_FLO] = i_output_freq < i_low_freq_limit;
    raw[`LWM_W_FHI] = i_output_freq > high_frequency_limit;
    raw[`LWM_W_RLO] = i_remote_ref_sel && (i_remote_ref < ref_lo);
    raw[`LWM_W_RHI] = i_remote_ref_sel && (i_result_ref > ref_hi);
    raw[`LWM_W_BLO] = i_feedback < fb_lo;
    raw[`LWM_W_BHI] = i_feedback > fb_hi;
  end

  // low current is a warning only in warn mode
  always_comb begin
    warn_nxt = enable ? raw : '0;
    if (i_noload_action == `LWM_NOLOAD_TRIP) warn_nxt[`LWM_W_ILO] = 1'b0;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) warn_r <= '0;
    else warn_r <= warn_nxt;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) trip_r <= 1'b0;
    else if (enable && raw[`LWM_W_ILO] &&
             i_noload_action == `LWM_NOLOAD_TRIP) trip_r <= 1'b1;
  end

  // Slow blink so the display flash is visible
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      blink_cnt_r <= '0;
      blink_r <= 1'b0;
    end else if (blink_cnt_r >= BLINK_CYC - 1) begin
      blink_cnt_r <= '0;
      blink_r <= ~blink_r;
    end else begin
      blink_cnt_r <= blink_cnt_r + 32'd1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) warn_flash_r <= '0;
    else warn_flash_r <= warn_nxt & {`LWM_NWARN{~blink_r}};
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      o_sig_out <= 1'b0;
      o_relay_out <= 1'b0;
    end else begin
      o_sig_out <= |(warn_nxt & i_route_sig);
      o_relay_out <= |(warn_nxt & i_route_relay);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      o_monitor_en <= 1'b0;
      o_limit_err <= 1'b0;
    end else begin
      o_monitor_en <= enable;
      o_limit_err <= lim_bad;
    end
  end

  assign o_warn = warn_r;
  assign o_warn_flash = warn_flash_r;
  assign o_trip = trip_r;

  // Ramp finished at the reference, then the window opens
  sequence s_reach_ref;
    state_r == LWM_RAMPING && i_running && !i_stop_cmd && i_at_reference;
  endsequence
  sequence s_monitoring;
    state_r == LWM_ACTIVE;
  endsequence

  AST_SUPPRESS: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    !enable |=> o_warn == '0)
    else $error("warning while suppressed");
  AST_ENABLE: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_warn != '0 |-> $past(state_r) == LWM_ACTIVE)
    else $error("warning before reference reached");
  AST_WINDOW: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    s_reach_ref |=> s_monitoring)
    else $error("monitoring not opened at reference");
  AST_LOW_CUR: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    enable && i_motor_current < cur_lo && i_noload_action
    |=> o_warn[`LWM_W_ILO])
    else $error("low current warning missing");
  AST_TRIP: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    enable && i_motor_current < cur_lo && !i_noload_action
    |=> o_trip && !o_warn[`LWM_W_ILO])
    else $error("low current trip missing");
  AST_TRIP_HOLD: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_trip |=> o_trip)
    else $error("trip released without reset");
  AST_HI_CUR: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    enable |=> o_warn[`LWM_W_IHI] == $past(i_motor_current > cur_hi))
    else $error("high current warning wrong");
  AST_FREQ: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    enable |=> o_warn[`LWM_W_FLO] == $past(i_output_freq < i_low_freq_limit)
    && o_warn[`LWM_W_FHI] == $past(i_output_freq > high_frequency_limit))
    else $error("frequency warning wrong");
  AST_REF: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    enable |=> o_warn[`LWM_W_RLO] ==
    $past(i_remote_ref_sel && i_remote_ref < ref_lo)
    && o_warn[`LWM_W_RHI] ==
    $past(i_remote_ref_sel && i_result_ref > ref_hi))
    else $error("reference warning wrong");
  AST_REF_SEL: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    !i_remote_ref_sel |=> o_warn[`LWM_W_RHI:`LWM_W_RLO] == 2'b00)
    else $error("reference warning without remote");
  AST_FB: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    enable |=> o_warn[`LWM_W_BLO] == $past(i_feedback < fb_lo)
    && o_warn[`LWM_W_BHI] == $past(i_feedback > fb_hi))
    else $error("feedback warning wrong");
  AST_FLASH: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (o_warn_flash & ~o_warn) == '0)
    else $error("flash without warning");
  AST_ROUTE: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_relay_out == |(o_warn & $past(i_route_relay)))
    else $error("relay routing wrong");
  AST_SIG_ROUTE: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_sig_out == |(o_warn & $past(i_route_sig)))
    else $error("signal routing wrong");
endmodule

//--- verification/lwm_drive_model.sv
`timescale 1ns/1ps
module lwm_drive_model (
  // Clock and command
  input wire logic i_mclk,
  input wire logic i_start,
  // Drive state
  output logic o_running,
  output logic o_stop_cmd,
  output logic o_at_ref
);
  logic [2:0] ramp_r;
  initial begin
    o_running = 1'b0;
    o_stop_cmd = 1'b0;
    o_at_ref = 1'b0;
    ramp_r = 3'h0;
  end
  // Non-blocking on the edge, so the bench's negedge writes never race
  always @(posedge i_mclk) begin
    o_stop_cmd <= !i_start;
    if (i_start) begin
      o_running <= 1'b1;
      ramp_r <= (ramp_r == 3'h4) ? ramp_r : ramp_r + 3'h1;
    end else begin
      // Ramp down keeps the motor turning a few cycles
      o_running <= ramp_r != 3'h0;
      ramp_r <= (ramp_r == 3'h0) ? ramp_r : ramp_r - 3'h1;
    end
    o_at_ref <= i_start && ramp_r == 3'h4;
  end
endmodule

//--- verification/lwm_monitor_tb.sv
`timescale 1ns/1ps
`include "lwm_regs.svh"
module lwm_monitor_tb;
  logic clk = 0, rstn = 0, start = 0, remote = 1, noload = 1;
  logic running, stop_cmd, at_ref, sig, relay, trip, men, lerr;
  logic [15:0] cur, freq, mx = 16'h03e8, lc = 16'h0032, hc = 16'h00c8;
  logic [15:0] lf = 16'h0032, hf = 16'h00c8;
  logic signed [31:0] rref, resref, fb, lr = -32'sd1000, hr = 32'sd1000;
  logic signed [31:0] lb = -32'sd1000, hb = 32'sd1000;
  logic [7:0] warn, flash, fon, foff, rs = 8'h55, rr = 8'h0f;
  int failures = 0, checked = 0;
  initial forever #5 clk = ~clk;
  lwm_drive_model u_drv (.i_mclk(clk), .i_start(start), .o_running(running),
    .o_stop_cmd(stop_cmd), .o_at_ref(at_ref));
  lwm_monitor #(.BLINK_CYC(4)) u_dut (.i_mclk(clk), .i_rstn(rstn),
    .i_running(running), .i_stop_cmd(stop_cmd), .i_at_reference(at_ref),
    .i_remote_ref_sel(remote), .i_noload_action(noload),
    .i_motor_current(cur), .i_output_freq(freq), .i_remote_ref(rref),
    .i_result_ref(resref), .i_feedback(fb), .i_max_current(mx),
    .low_current_limit(lc), .high_current_limit(hc), .i_low_freq_limit(lf),
    .high_frequency_limit(hf), .low_reference_limit(lr),
    .high_reference_limit(hr), .low_feedback_limit(lb),
    .high_feedback_limit(hb), .i_route_sig(rs), .i_route_relay(rr),
    .o_warn(warn), .o_warn_flash(flash), .o_sig_out(sig), .o_relay_out(relay),
    .o_trip(trip), .o_monitor_en(men), .o_limit_err(lerr));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  task base;
    cur = 16'h0064;
    freq = 16'h0064;
    rref = 0;
    resref = 0;
    fb = 0;
  endtask
  task t_ramp;
    start = 1;
    wait_n(2);
    cur = 16'h012c;
    wait_n(2);
    chk(warn, 8'h00);
    wait_n(8);
    chk({7'h0, men}, 8'h01);
    chk(warn, 8'h02);
    fon = 8'h00;
    foff = 8'h00;
    repeat (8) begin
      wait_n(1);
      fon = fon | flash;
      foff = foff | (warn & ~flash);
    end
    chk(fon, 8'h02);
    chk(foff, 8'h02);
    cur = hc;
    wait_n(3);
    chk(warn, 8'h00);
  endtask
  task t_limits;
    for (int k = 0; k < 8; k++) begin
      base();
      case (k)
        0: cur = 16'h0028;
        1: cur = 16'h012c;
        2: freq = 16'h0028;
        3: freq = 16'h012c;
        4: rref = -32'sd2000;
        5: resref = 32'sd2000;
        6: fb = -32'sd2000;
        default: fb = 32'sd2000;
      endcase
      wait_n(3);
      chk(warn, 8'h01 << k);
      chk({6'h0, sig, relay}, {6'h0, rs[k], rr[k]});
    end
    base();
    lc = 16'h0100;
    wait_n(3);
    chk({7'h0, lerr}, 8'h01);
    lc = 16'h0032;
  endtask
  task t_local;
    remote = 0;
    rref = -32'sd2000;
    resref = 32'sd2000;
    wait_n(3);
    chk(warn, 8'h00);
    chk({7'h0, lerr}, 8'h00);
    base();
    remote = 1;
  endtask
  task t_stop;
    cur = 16'h012c;
    start = 0;
    wait_n(3);
    chk(warn, 8'h00);
    chk({7'h0, men}, 8'h00);
    wait_n(4);
    chk(warn, 8'h00);
    base();
  endtask
  task t_trip;
    start = 1;
    wait_n(12);
    noload = 0;
    cur = 16'h0028;
    wait_n(3);
    chk({7'h0, trip}, 8'h01);
    chk(warn & 8'h01, 8'h00);
    rstn = 0;
    wait_n(2);
    rstn = 1;
    wait_n(1);
    chk({7'h0, trip}, 8'h00);
    chk(warn, 8'h00);
  endtask
  initial begin
    base();
    wait_n(16);
    rstn = 1;
    t_ramp();
    t_limits();
    t_local();
    t_stop();
    t_trip();
    finish_test();
  end
  // Run needs about 94 cycles
  initial begin
    #20000;
    failures++;
    finish_test();
  end
endmodule
